/* pio_pkg.sv */
package pio_pkg;

   // ----------------------------------------------------------------
   // pin modes and input cell modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_MCU  = 3'h0,
      MODE_CELL = 3'h1,
      MODE_ADDR = 3'h2,
      MODE_PERI = 3'h3,
      MODE_CSEL = 3'h4,
      MODE_TEST = 3'h5
   } pio_mode_t;

   typedef enum logic [1:0] {
      IN_PASS  = 2'h0,
      IN_LATCH = 2'h1,
      IN_CLOCK = 2'h2
   } pio_inmode_t;

   // ----------------------------------------------------------------
   // register offsets, index is the port (0 = A .. 3 = D)
   // ----------------------------------------------------------------
   localparam logic [3:0][7:0] OFF_DIN  = {8'h11, 8'h10, 8'h01, 8'h00};
   localparam logic [3:0][7:0] OFF_DOUT = {8'h13, 8'h12, 8'h05, 8'h04};
   localparam logic [3:0][7:0] OFF_DIR  = {8'h15, 8'h14, 8'h07, 8'h06};
   localparam logic [3:0][7:0] OFF_DRV  = {8'h17, 8'h16, 8'h09, 8'h08};
   localparam logic [3:0][7:0] OFF_OEN  = {8'h1B, 8'h1A, 8'h0D, 8'h0C};
   localparam logic [1:0][7:0] OFF_CTL  = {8'h03, 8'h02};
   localparam logic [2:0][7:0] OFF_CIN  = {8'h18, 8'h0B, 8'h0A};
   localparam logic [7:0]      OFF_MAP  = 8'h30;

   // ----------------------------------------------------------------
   // field positions, masks and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0][7:0] PORT_MASK = {8'h06, 8'h9C, 8'hFF, 8'hFF};
   localparam logic [7:0]      TEST_PINS  = 8'h63;
   localparam int              MAP_PERI_BIT = 7;
   localparam int              BIT_STAT   = 3;
   localparam int              BIT_ERR    = 4;
   localparam int              BIT_TDO    = 6;
   localparam logic [7:0]      RST_REG    = 8'h00;

endpackage

/* pio_pin_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pio_pin_if;
   pio_pkg::pio_mode_t mode;
   logic dir, ctl, dout, drv, peri_en;
   logic cell_d, addr_d, per_d, per_oe, arr_oe, fix_d, fix_oe;
   logic pad_o, pad_oe;

   modport ctrl (output mode, dir, ctl, dout, drv, peri_en, cell_d, addr_d,
                 per_d, per_oe, arr_oe, fix_d, fix_oe,
                 input pad_o, pad_oe);
   modport pin  (input mode, dir, ctl, dout, drv, peri_en, cell_d, addr_d,
                 per_d, per_oe, arr_oe, fix_d, fix_oe,
                 output pad_o, pad_oe);
endinterface
`default_nettype wire

/* pio_pin.sv */
`timescale 1ns/100ps
`default_nettype none
module pio_pin (
   input  wire logic clk_sys, // system clock
   input  wire logic rst,     // synchronous reset
   pio_pin_if.pin    pif      // controls from the port logic
);
   typedef struct packed {
      logic o;
      logic oe;
   } pio_pin_st_t;

   pio_pin_st_t q, d;

   always_comb begin
      d = q;
      // ------------------------------------------------------------
      // output source select
      // ------------------------------------------------------------
      case (pif.mode)
         pio_pkg::MODE_CELL, pio_pkg::MODE_CSEL: begin
            d.o = pif.cell_d; // data out ignored here
         end
         pio_pkg::MODE_ADDR: begin
            // needs both control and direction set
            d.o = (pif.ctl & pif.dir) ? pif.addr_d : pif.dout;
         end
         pio_pkg::MODE_PERI: begin
            d.o = pif.peri_en ? pif.per_d : pif.dout;
         end
         pio_pkg::MODE_TEST: begin
            d.o = pif.fix_d;
         end
         default: begin
            d.o = pif.dout;
         end
      endcase
      // ------------------------------------------------------------
      // driver enable
      // ------------------------------------------------------------
      if (pif.mode == pio_pkg::MODE_TEST) begin
         d.oe = pif.fix_oe;
      end else begin
         // direction alone when arr_oe and the peripheral term are idle
         d.oe = pif.arr_oe | pif.dir
              | (pif.mode == pio_pkg::MODE_PERI & pif.peri_en & pif.per_oe);
         // open drain: high level is released, not driven
         if (pif.drv & d.o) begin
            d.oe = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pif.pad_o  = q.o;
   assign pif.pad_oe = q.oe;
endmodule // pio_pin
`default_nettype wire

/* pio_incell.sv */
`timescale 1ns/100ps
`default_nettype none
module pio_incell (
   input  wire logic               clk_sys, // system clock
   input  wire logic               rst,     // synchronous reset
   input  wire logic [7:0]         pin,     // pin levels
   input  wire pio_pkg::pio_inmode_t mode,  // strobe style
   input  wire logic [1:0]         strobe,  // term per group of four
   output logic      [7:0]         cell_q   // captured levels
);
   typedef struct packed {
      logic [7:0] q;
      logic [1:0] stb;
   } pio_incell_st_t;

   pio_incell_st_t q, d;
   logic [7:0]     nxt;

   // ----------------------------------------------------------------
   // per-bit capture
   // ----------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         logic g;
         assign g = strobe[b / 4];
         always_comb begin
            case (mode)
               pio_pkg::IN_LATCH: nxt[b] = g ? pin[b] : q.q[b];
               // rising edge of the term acts as the clock
               pio_pkg::IN_CLOCK: nxt[b] = (g & ~q.stb[b / 4]) ? pin[b]
                                                               : q.q[b];
               default:           nxt[b] = pin[b];
            endcase
         end
      end
   endgenerate

   always_comb begin
      d     = q;
      d.q   = nxt;
      d.stb = strobe;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cell_q = q.q;
endmodule // pio_incell
`default_nettype wire

/* pio_top.sv */
// Operation
// - output mux picks data out, latched address, peripheral or cell data
// - mux select comes from configuration plus run-time control bits
// - a register read puts at most one source on the read data
// - direction, drive, control, data out, enable and pin level readable
// - driver enable is logic-array term OR direction bit, plus peripheral enable in peripheral mode; drive bit releases high
// - with no other enable sources the direction bit alone drives
// - each pin of ports A..C feeds both data-in read and its input cell; data-in reads C0, C1, C5, C6 as 0
// - logic-array output mode works from configuration alone
// - general-purpose mode is run-time register controlled, the array term also enables
// - port C group two on pins 2,3,4,7; groups and selects per port
// - port C pins 0,1,5,6 are test-port pins, never general I/O
// - six-pin option puts status on C3, error on C4
// - direction 0 input, 1 drives data out; control defaults 0
// - data in reads live pins, data out sets driven levels
// - direction changeable any time, mixed within one port
// - port A input register at 00h, only on larger package
// - direction and data out reset to 00h
// - data out writes do not reach a logic-array output pin
// - logic-array input pin readable, direction still drives
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module pio_top #(
   parameter bit LARGE_PKG = 1'b1                      // port A present
) (
   input  wire logic                     clk_sys,      // system clock
   input  wire logic                     rst,          // sync reset
   input  wire logic [7:0]               reg_addr,     // register offset
   input  wire logic [7:0]               reg_wdata,    // write data
   input  wire logic                     reg_wr,       // write strobe
   input  wire logic                     reg_rd,       // read strobe
   output logic      [7:0]               reg_rdata,    // read data
   input  wire logic [31:0]              pin_level,    // pin levels A..D
   output logic      [31:0]              pin_drive,    // pin output value
   output logic      [31:0]              pin_oe,       // pin driver on
   input  wire pio_pkg::pio_mode_t [31:0] cfg_mode,    // configured mode
   input  wire logic [7:0]               cfg_b_grp2,   // port B group two
   input  wire logic                     cfg_six_pin,  // six-pin test port
   input  wire pio_pkg::pio_inmode_t [2:0] cfg_in_mode,// input cell style
   input  wire logic [7:0]               output_cell_group_one, // cells
   input  wire logic [7:0]               output_cell_group_two, // cells
   input  wire logic [7:0]               chip_sel,     // port D selects
   input  wire logic [31:0]              arr_oe,       // array enables
   input  wire logic [15:0]              lat_addr,     // latched address
   input  wire logic [7:0]               peri_data,    // peripheral data
   input  wire logic [7:0]               peri_oe,      // peripheral enable
   input  wire logic [5:0]               in_strobe,    // input cell terms
   input  wire logic                     prog_status,  // programming status
   input  wire logic                     prog_error,   // programming error
   input  wire logic                     tdo_data,     // test data out
   input  wire logic                     tdo_oe,       // test data enable
   output logic      [23:0]              input_logic_cell // cells A..C
);
   typedef struct packed {
      logic [3:0][7:0] dout;
      logic [3:0][7:0] dir;
      logic [3:0][7:0] drv;
      logic [1:0][7:0] ctl;
      logic [7:0]      map;
      logic [7:0]      rdata;
   } pio_regs_t;

   pio_regs_t   q, d;
   logic [31:0] oe_now;
   logic [7:0]  pmask [4];

   // ----------------------------------------------------------------
   // legal modes per pin
   // ----------------------------------------------------------------
   function automatic pio_pkg::pio_mode_t fix_mode(
      input int unsigned i, input pio_pkg::pio_mode_t m, input logic six);
      int unsigned p;
      int unsigned b;
      pio_pkg::pio_mode_t r;
      p = i / 8;
      b = i % 8;
      r = pio_pkg::MODE_MCU;
      case (m)
         pio_pkg::MODE_CELL: if (p < 3) r = m;
         pio_pkg::MODE_ADDR: if (p < 2) r = m;
         pio_pkg::MODE_PERI: if (p == 0) r = m;
         pio_pkg::MODE_CSEL: if (p == 3) r = m;
         default:            r = pio_pkg::MODE_MCU;
      endcase
      if (p == 0 && !LARGE_PKG) r = pio_pkg::MODE_MCU;
      if (p == 2 && pio_pkg::TEST_PINS[b]) r = pio_pkg::MODE_TEST;
      if (p == 2 && six && (b == pio_pkg::BIT_STAT || b == pio_pkg::BIT_ERR))
         r = pio_pkg::MODE_TEST;
      return r;
   endfunction

   always_comb begin
      pmask[0] = LARGE_PKG ? pio_pkg::PORT_MASK[0] : 8'h00;
      pmask[1] = pio_pkg::PORT_MASK[1];
      pmask[2] = pio_pkg::PORT_MASK[2];
      pmask[3] = pio_pkg::PORT_MASK[3];
   end

   // ----------------------------------------------------------------
   // register writes and read-back
   // ----------------------------------------------------------------
   always_comb begin
      d       = q;
      d.rdata = 8'h00;
      if (reg_wr) begin
         // data-in offsets have no write path
         for (int p = 0; p < 4; p++) begin
            if (reg_addr == pio_pkg::OFF_DOUT[p])
               d.dout[p] = reg_wdata & pmask[p];
            if (reg_addr == pio_pkg::OFF_DIR[p])
               d.dir[p] = reg_wdata & pmask[p];
            if (reg_addr == pio_pkg::OFF_DRV[p])
               d.drv[p] = reg_wdata & pmask[p];
         end
         for (int p = 0; p < 2; p++) begin
            if (reg_addr == pio_pkg::OFF_CTL[p])
               d.ctl[p] = reg_wdata & pmask[p];
         end
         if (reg_addr == pio_pkg::OFF_MAP)
            d.map = reg_wdata;
      end
      if (reg_rd) begin
         // offsets are distinct, so one source at most
         for (int p = 0; p < 4; p++) begin
            if (reg_addr == pio_pkg::OFF_DIN[p])
               d.rdata = pin_level[p*8 +: 8] & pmask[p];
            if (reg_addr == pio_pkg::OFF_DOUT[p]) d.rdata = q.dout[p];
            if (reg_addr == pio_pkg::OFF_DIR[p])  d.rdata = q.dir[p];
            if (reg_addr == pio_pkg::OFF_DRV[p])  d.rdata = q.drv[p];
            if (reg_addr == pio_pkg::OFF_OEN[p])
               d.rdata = oe_now[p*8 +: 8] & pmask[p];
         end
         for (int p = 0; p < 2; p++) begin
            if (reg_addr == pio_pkg::OFF_CTL[p]) d.rdata = q.ctl[p];
         end
         for (int p = 0; p < 3; p++) begin
            if (reg_addr == pio_pkg::OFF_CIN[p])
               d.rdata = input_logic_cell[p*8 +: 8] & pmask[p];
         end
         if (reg_addr == pio_pkg::OFF_MAP) d.rdata = q.map;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0; // all registers clear to 00h
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;

   // ----------------------------------------------------------------
   // pin slices
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_pin
         localparam int P = i / 8;
         localparam int B = i % 8;
         pio_pin_if pif ();

         assign pif.mode    = fix_mode(i, cfg_mode[i], cfg_six_pin);
         assign pif.dir     = q.dir[P][B];
         assign pif.ctl     = (P < 2) ? q.ctl[P % 2][B] : 1'b0;
         assign pif.dout    = q.dout[P][B];
         assign pif.drv     = q.drv[P][B];
         assign pif.peri_en = q.map[pio_pkg::MAP_PERI_BIT];
         // source per port: group one, two or selects
         assign pif.cell_d  = (P == 0) ? output_cell_group_one[B]
                            : (P == 1) ? (cfg_b_grp2[B]
                                          ? output_cell_group_two[B]
                                          : output_cell_group_one[B])
                            : (P == 2) ? output_cell_group_two[B]
                            : chip_sel[B];
         assign pif.addr_d  = (P < 2) ? lat_addr[i % 16] : 1'b0;
         assign pif.per_d   = (P == 0) ? peri_data[B] : 1'b0;
         assign pif.per_oe  = (P == 0) ? peri_oe[B] : 1'b0;
         assign pif.arr_oe  = arr_oe[i];
         // fixed test-port drivers
         assign pif.fix_d   = (P != 2)                 ? 1'b0
                            : (B == pio_pkg::BIT_TDO)  ? tdo_data
                            : (B == pio_pkg::BIT_STAT) ? prog_status
                            : (B == pio_pkg::BIT_ERR)  ? prog_error
                            : 1'b0;
         assign pif.fix_oe  = (P != 2)                 ? 1'b0
                            : (B == pio_pkg::BIT_TDO)  ? tdo_oe
                            : (B == pio_pkg::BIT_STAT
                               || B == pio_pkg::BIT_ERR) ? cfg_six_pin
                            : 1'b0;

         pio_pin u_pin (
            .clk_sys (clk_sys),
            .rst     (rst),
            .pif     (pif)
         );

         assign pin_drive[i] = pif.pad_o;
         assign pin_oe[i]    = pif.pad_oe;
         assign oe_now[i]    = pif.pad_oe;
      end

      // ----------------------------------------------------------------
      // input cells, ports A..C
      // ----------------------------------------------------------------
      for (i = 0; i < 3; i++) begin : g_cell
         pio_incell u_cell (
            .clk_sys (clk_sys),
            .rst     (rst),
            .pin     (pin_level[i*8 +: 8]),
            .mode    (cfg_in_mode[i]),
            .strobe  (in_strobe[i*2 +: 2]),
            .cell_q  (input_logic_cell[i*8 +: 8])
         );
      end
   endgenerate
endmodule // pio_top
`default_nettype wire

/* pio_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pio_chk (
   input wire logic                      clk_sys,     // clock
   input wire logic                      rst,         // reset
   input wire logic [7:0]                reg_addr,    // offset
   input wire logic [7:0]                reg_wdata,   // write data
   input wire logic                      reg_wr,      // write
   input wire logic                      reg_rd,      // read
   input wire logic [7:0]                reg_rdata,   // read data
   input wire logic [31:0]               pin_level,   // pins in
   input wire logic [31:0]               pin_drive,   // pins out
   input wire logic [31:0]               pin_oe,      // enables
   input wire pio_pkg::pio_mode_t [31:0] cfg_mode,    // modes
   input wire logic [7:0]                cfg_b_grp2,  // group pick
   input wire logic                      cfg_six_pin, // six-pin
   input wire logic [7:0]                output_cell_group_one, // cells
   input wire logic [31:0]               arr_oe,      // array oe
   input wire logic                      prog_status, // status
   input wire logic                      prog_error,  // error
   input wire logic                      tdo_data,    // tdo
   input wire logic                      tdo_oe       // tdo enable
);
   logic [7:0] dir_q;
   logic [7:0] dout_q;
   logic [7:0] drv_q;
   logic       mcu_a;
   // ---------------------------------------------------------------
   // port A shadow, so pin outputs can be predicted
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dir_q  <= 8'h00;
         dout_q <= 8'h00;
         drv_q  <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            8'h04: dout_q <= reg_wdata;
            8'h06: dir_q <= reg_wdata;
            pio_pkg::OFF_DRV[0]: drv_q <= reg_wdata;
            default: ;
         endcase
      end
   end
   always_comb begin
      mcu_a = 1'b1;
      for (int i = 0; i < 8; i++) begin
         mcu_a = mcu_a & (cfg_mode[i] == pio_pkg::MODE_MCU);
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read cycle");
   property p_din_a;
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(pin_level[7:0]);
   endproperty
   a_din_a: assert property (p_din_a)
      else $error("port A input read is not the live pins");
   property p_oe_or;
      $past(mcu_a && drv_q == 8'h00 && !rst)
         |-> pin_oe[7:0] == $past(arr_oe[7:0] | dir_q);
   endproperty
   a_oe_or: assert property (p_oe_or)
      else $error("port A enable is not array term or direction");
   property p_drive_mcu;
      $past(mcu_a && !rst)
         |-> (pin_drive[7:0] & pin_oe[7:0]) == ($past(dout_q) & pin_oe[7:0]);
   endproperty
   a_drive_mcu: assert property (p_drive_mcu)
      else $error("port A driven value is not data out");
   property p_test_pins;
      !$past(rst) |-> pin_oe[17:16] == 2'b00 && !pin_oe[21]
         && pin_oe[22] == $past(tdo_oe)
         && (!pin_oe[22] || pin_drive[22] == $past(tdo_data));
   endproperty
   a_test_pins: assert property (p_test_pins)
      else $error("test port pins misbehave");
   property p_six;
      $past(cfg_six_pin && !rst) |-> pin_oe[20:19] == 2'b11
         && pin_drive[20:19] == {$past(prog_error), $past(prog_status)};
   endproperty
   a_six: assert property (p_six)
      else $error("status or error pin not carried");
   property p_cell;
      $past(cfg_mode[8] == pio_pkg::MODE_CELL && !cfg_b_grp2[0] && !rst)
         |-> pin_drive[8] == $past(output_cell_group_one[0]);
   endproperty
   a_cell: assert property (p_cell)
      else $error("cell pin not driven from its cell");
   property p_rst;
      disable iff (1'b0) rst |=> pin_oe == 32'h0000_0000 && reg_rdata == 8'h00;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
endmodule // pio_chk
`default_nettype wire

/* pio_ext.sv */
`timescale 1ns/100ps
`default_nettype none
module pio_ext (
   input  wire logic [31:0] pin_drive, // device value
   input  wire logic [31:0] pin_oe,    // device enable
   input  wire logic [31:0] ext_val,   // outside value
   input  wire logic [31:0] ext_oe,    // outside enable
   output logic      [31:0] pin_level  // resolved wire
);
   // ---------------------------------------------------------------
   // wire resolution
   // ---------------------------------------------------------------
   // device wins a clash; a floating pin rests on its pull-up
   assign pin_level = (pin_oe & pin_drive) | (~pin_oe & ext_oe & ext_val)
                    | (~pin_oe & ~ext_oe);
endmodule // pio_ext
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [31:0] pin_level, pin_drive, pin_oe, arr_oe = 32'h0;
   logic [31:0] ext_val = 32'h0, ext_oe = 32'h0;
   pio_pkg::pio_mode_t [31:0] cfg_mode;
   pio_pkg::pio_inmode_t [2:0] cfg_in_mode;
   logic six = 1'b0, stat = 1'b0, err = 1'b0, tdo_d = 1'b0, tdo_e = 1'b0;
   logic [7:0] cell1 = 8'h00, cell2 = 8'h00, csel = 8'h00, grp2 = 8'h00;
   logic [7:0] peri_d = 8'h00, peri_e = 8'h00;
   logic [15:0] lat = 16'h0;
   logic [5:0] strb = 6'h0;
   logic [23:0] in_cell;
   int n_errors = 0, compares = 0, cycles = 0;
   pio_top u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_level(pin_level), .pin_drive(pin_drive),
      .pin_oe(pin_oe), .cfg_mode(cfg_mode), .cfg_b_grp2(grp2),
      .cfg_six_pin(six), .cfg_in_mode(cfg_in_mode),
      .output_cell_group_one(cell1), .output_cell_group_two(cell2),
      .chip_sel(csel), .arr_oe(arr_oe), .lat_addr(lat), .peri_data(peri_d),
      .peri_oe(peri_e), .in_strobe(strb), .prog_status(stat),
      .prog_error(err), .tdo_data(tdo_d), .tdo_oe(tdo_e),
      .input_logic_cell(in_cell));
   pio_ext u_ext (.pin_drive(pin_drive), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pin_level(pin_level));
   // ---------------------------------------------------------------
   // clock, watchdog, bus and compare tasks
   // ---------------------------------------------------------------
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk({24'h0, reg_rdata}, {24'h0, exp});
   endtask
   // pin effects land one edge after the write edge
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk(pin_oe, 32'h0);
      rdc(8'h06, 8'h00);
      rdc(8'h04, 8'h00);
      rdc(8'h02, 8'h00);
   endtask
   task automatic t_gpio();
      @(posedge clk_sys);
      ext_oe <= 32'h0000_00F0;
      ext_val <= 32'h0000_00A0;
      wr(8'h06, 8'h0F);
      wr(8'h04, 8'hA5);
      settle();
      chk(pin_oe & 32'hFF, 32'h0F);
      chk(pin_drive & 32'h0F, 32'h05);
      chk({8'h0, in_cell} & 32'hFF, 32'hA5);
      rdc(8'h00, 8'hA5);
      rdc(8'h06, 8'h0F);
      rdc(8'h0C, 8'h0F);
      wr(8'h00, 8'h00);
      rdc(8'h06, 8'h0F);
      rdc(8'h00, 8'hA5);
      rdc(8'h3F, 8'h00);
   endtask
   task automatic t_oe_or();
      @(posedge clk_sys);
      ext_oe <= 32'h0;
      arr_oe <= 32'h0000_003C;
      wr(8'h06, 8'h00);
      settle();
      chk(pin_oe & 32'hFF, 32'h3C);
      wr(8'h06, 8'hC0);
      rdc(8'h0C, 8'hFC);
      settle();
      chk(pin_oe & 32'hFF, 32'hFC);
      @(posedge clk_sys);
      arr_oe <= 32'h0;
   endtask
   task automatic t_cell();
      @(posedge clk_sys);
      cfg_mode[8] <= pio_pkg::MODE_CELL;
      cell1 <= 8'h01;
      wr(8'h07, 8'h01);
      wr(8'h05, 8'h00);
      settle();
      chk({31'h0, pin_drive[8]}, 32'h1);
      @(posedge clk_sys);
      cell1 <= 8'h00;
      wr(8'h05, 8'h01);
      settle();
      chk({31'h0, pin_drive[8]}, 32'h0);
   endtask
   task automatic t_mux();
      @(posedge clk_sys);
      cfg_mode[0] <= pio_pkg::MODE_ADDR;
      cfg_mode[1] <= pio_pkg::MODE_PERI;
      lat <= 16'h0001;
      peri_d <= 8'h02;
      peri_e <= 8'h02;
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h01);
      wr(8'h06, 8'h01);
      wr(pio_pkg::OFF_MAP, 8'h80);
      settle();
      chk(pin_drive & 32'h3, 32'h3);
      chk(pin_oe & 32'h3, 32'h3);
   endtask
   task automatic t_test();
      @(posedge clk_sys);
      tdo_e <= 1'b1;
      tdo_d <= 1'b1;
      six <= 1'b1;
      stat <= 1'b1;
      wr(8'h14, 8'hFF);
      settle();
      chk({24'h0, pin_oe[23:16]}, 32'hDC);
      chk(pin_drive & 32'h0058_0000, 32'h0048_0000);
      rdc(8'h14, 8'h9C);
   endtask
   // open drain on port A, chip select on D1, latched input cells on B
   task automatic t_more();
      @(posedge clk_sys);
      cfg_mode[25] <= pio_pkg::MODE_CSEL;
      csel <= 8'h02;
      cfg_in_mode[1] <= pio_pkg::IN_LATCH;
      wr(8'h08, 8'hFF);
      rdc(8'h08, 8'hFF);
      @(posedge clk_sys);
      cell1 <= 8'h01;
      settle();
      chk({31'h0, pin_drive[25]}, 32'h1);
      chk({24'h0, in_cell[15:8]}, 32'hFE);
      rdc(8'h0C, 8'h00);
      @(posedge clk_sys);
      strb <= 6'h04;
      settle();
      chk({24'h0, in_cell[15:8]}, 32'hFF);
   endtask
   initial begin
      for (int i = 0; i < 32; i++) begin
         cfg_mode[i] <= pio_pkg::MODE_MCU;
         if (i < 3) cfg_in_mode[i] <= pio_pkg::IN_PASS;
      end
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_gpio();
      t_oe_or();
      t_cell();
      t_mux();
      t_test();
      t_more();
      stop_test();
   end
endmodule // tb_top
bind pio_top pio_chk u_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_level(pin_level),
   .pin_drive(pin_drive), .pin_oe(pin_oe), .cfg_mode(cfg_mode),
   .cfg_b_grp2(cfg_b_grp2), .cfg_six_pin(cfg_six_pin),
   .output_cell_group_one(output_cell_group_one), .arr_oe(arr_oe),
   .prog_status(prog_status), .prog_error(prog_error),
   .tdo_data(tdo_data), .tdo_oe(tdo_oe));
`default_nettype wire
